/* core/umc_pkg.sv */
// umc_pkg: register map, field positions and codes for the serial port
// mode control block.
// assumes a 16-bit register port with word addresses.
package umc_pkg;
    localparam int          UMC_ADDR_W     = 2;
    localparam int          UMC_DATA_W     = 16;
    // register word addresses
    localparam logic [1:0]  UMC_OFS_MODE   = 2'h0;
    localparam logic [1:0]  UMC_OFS_STAT   = 2'h1;
    localparam logic [1:0]  UMC_OFS_MASK   = 2'h2;
    // serial_port_mode fields
    localparam int          UMC_B_PORT_ON  = 15;
    localparam int          UMC_B_IDLE     = 13;
    localparam int          UMC_B_IR_ON    = 12;
    localparam int          UMC_B_RTS_MODE = 11;
    localparam int          UMC_B_USAGE_HI = 9;
    localparam int          UMC_B_USAGE_LO = 8;
    localparam int          UMC_B_WAKE     = 7;
    localparam int          UMC_B_LOOP     = 6;
    localparam int          UMC_B_AUTORATE = 5;
    localparam int          UMC_B_RX_INV   = 4;
    localparam int          UMC_B_HI_SPEED = 3;
    localparam int          UMC_B_PAR_HI   = 2;
    localparam int          UMC_B_PAR_LO   = 1;
    localparam int          UMC_B_STOP     = 0;
    // bits 14 and 10 are not implemented
    localparam logic [15:0] UMC_MODE_WMASK = 16'hbbff;
    localparam logic [15:0] UMC_MODE_RST   = 16'h0000;
    // pin usage codes
    localparam logic [1:0]  UMC_USE_TXRX   = 2'h0;
    localparam logic [1:0]  UMC_USE_RTS    = 2'h1;
    localparam logic [1:0]  UMC_USE_FLOW   = 2'h2;
    localparam logic [1:0]  UMC_USE_BCLK   = 2'h3;
    // interrupt status bits
    localparam int          UMC_EV_WAKE    = 0;
    localparam int          UMC_EV_MEASURE = 1;
    localparam int          UMC_EV_W       = 2;
    localparam logic [1:0]  UMC_EV_RST     = 2'h0;
endpackage : umc_pkg

/* core/umc_edge_det.sv */
// umc_edge_det: one-cycle rise and fall pulses of a synchronous level.
// assumes the input is already synchronous to i_mclk.
`timescale 1ns/1ps
module umc_edge_det #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    // level in, pulses out
    input  wire logic i_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic last_reg;
    logic last_next;

    always_comb begin
        last_next = i_level;
        o_rise    = i_level & ~last_reg;
        o_fall    = ~i_level & last_reg;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_reg <= RESET_LEVEL;
        end else begin
            last_reg <= last_next;
        end
    end
endmodule : umc_edge_det

/* core/umc_mode_ctrl.sv */
// umc_mode_ctrl: mode control of an asynchronous serial port.
// assumes a datapath and baud generator outside, a plain register port,
// and a pad ring that falls back to port latches when ownership drops.
`timescale 1ns/1ps
module umc_mode_ctrl (
    // clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_reset_n,
    // register port
    input  wire logic [umc_pkg::UMC_ADDR_W-1:0] i_addr,
    input  wire logic [umc_pkg::UMC_DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic [umc_pkg::UMC_DATA_W-1:0]  o_rdata,
    output logic                            o_irq,
    // processor power state
    input  wire logic                       i_cpu_idle,
    input  wire logic                       i_cpu_sleep,
    // datapath side
    input  wire logic                       i_tx_bit,
    input  wire logic                       i_ir_pulse,
    input  wire logic                       i_rx_ready,
    input  wire logic                       i_tx_busy,
    input  wire logic                       i_baud_clk,
    input  wire logic                       i_measure_done,
    output logic                            o_run,
    output logic                            o_low_power,
    output logic                            o_rx_bit,
    output logic                            o_rx_accept,
    output logic                            o_measure_active,
    output logic                            o_cts_allow,
    output logic [umc_pkg::UMC_DATA_W-1:0]  o_mode,
    // serial pins
    input  wire logic                       i_serial_rx_pin,
    output logic                            o_serial_tx_pin,
    output logic                            o_serial_tx_oe,
    output logic                            o_rts_bclk_pin,
    output logic                            o_rts_bclk_oe,
    input  wire logic                       i_clear_to_send_pin_n,
    // pin ownership, low hands the pin to the port latches
    output logic                            o_own_txrx,
    output logic                            o_own_rts,
    output logic                            o_own_cts,
    output logic                            o_own_bclk
);
    import umc_pkg::*;

    logic [15:0]         mode_reg, mode_next;
    logic [UMC_EV_W-1:0] stat_reg, stat_next;
    logic [UMC_EV_W-1:0] mask_reg, mask_next;
    logic [15:0]         rdata_reg, rdata_next;
    logic                irq_reg, irq_next;
    logic                wake_armed_reg, wake_armed_next;
    logic [13:0]         pins_reg, pins_next;
    logic                rx_rise, rx_fall;
    logic [1:0]          usage;
    logic                port_on, run_now, rx_eff;
    logic                wr_mode, wr_stat, wr_mask;
    logic [UMC_EV_W-1:0] ev_set;

    umc_edge_det #(
        .RESET_LEVEL (1'b1)
    ) u_rx_edge (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_level   (i_serial_rx_pin),
        .o_rise    (rx_rise),
        .o_fall    (rx_fall)
    );

    assign usage   = mode_reg[UMC_B_USAGE_HI:UMC_B_USAGE_LO];
    assign port_on = mode_reg[UMC_B_PORT_ON];
    assign wr_mode = i_wr && (i_addr == UMC_OFS_MODE);
    assign wr_stat = i_wr && (i_addr == UMC_OFS_STAT);
    assign wr_mask = i_wr && (i_addr == UMC_OFS_MASK);

    // register file, hardware-cleared bits and events
    always_comb begin
        mode_next       = mode_reg;
        wake_armed_next = wake_armed_reg;
        ev_set          = '0;
        if (mode_reg[UMC_B_WAKE] && i_cpu_sleep && rx_fall) begin
            ev_set[UMC_EV_WAKE] = 1'b1;
            wake_armed_next     = 1'b1;
        end
        if (mode_reg[UMC_B_WAKE] && wake_armed_reg && rx_rise) begin
            mode_next[UMC_B_WAKE] = 1'b0;
            wake_armed_next       = 1'b0;
        end
        if (!mode_reg[UMC_B_WAKE]) begin
            wake_armed_next = 1'b0;
        end
        if (mode_reg[UMC_B_AUTORATE] && i_measure_done) begin
            mode_next[UMC_B_AUTORATE] = 1'b0;
            ev_set[UMC_EV_MEASURE]    = 1'b1;
        end
        if (wr_mode) begin
            mode_next = i_wdata & UMC_MODE_WMASK;
        end
        // set wins over write-one-to-clear
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~i_wdata[UMC_EV_W-1:0];
        end
        stat_next = stat_next | ev_set;
        mask_next = wr_mask ? i_wdata[UMC_EV_W-1:0] : mask_reg;
        irq_next  = |(stat_next & mask_next);
        rdata_next = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                UMC_OFS_MODE: rdata_next = mode_reg & UMC_MODE_WMASK;
                UMC_OFS_STAT: rdata_next = {14'h0000, stat_reg};
                UMC_OFS_MASK: rdata_next = {14'h0000, mask_reg};
                default:      rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_reg       <= UMC_MODE_RST;
            stat_reg       <= UMC_EV_RST;
            mask_reg       <= UMC_EV_RST;
            rdata_reg      <= 16'h0000;
            irq_reg        <= 1'b0;
            wake_armed_reg <= 1'b0;
        end else begin
            mode_reg       <= mode_next;
            stat_reg       <= stat_next;
            mask_reg       <= mask_next;
            rdata_reg      <= rdata_next;
            irq_reg        <= irq_next;
            wake_armed_reg <= wake_armed_next;
        end
    end

    // pin and datapath steering, all registered
    always_comb begin
        run_now = port_on && !i_cpu_sleep &&
                  !(mode_reg[UMC_B_IDLE] && i_cpu_idle);
        // infrared decoder: a high pulse marks a zero bit
        rx_eff = mode_reg[UMC_B_IR_ON] ? ~i_serial_rx_pin : i_serial_rx_pin;
        if (mode_reg[UMC_B_RX_INV]) begin
            rx_eff = ~rx_eff;
        end
        if (mode_reg[UMC_B_LOOP]) begin
            rx_eff = i_tx_bit;
        end
        pins_next = '0;
        // [0] run, [1] low power, [2] rx bit, [3] rx accept, [4] measure
        pins_next[0] = run_now;
        pins_next[1] = !port_on;
        pins_next[2] = run_now ? rx_eff : 1'b1;
        pins_next[3] = run_now && !mode_reg[UMC_B_AUTORATE];
        pins_next[4] = run_now && mode_reg[UMC_B_AUTORATE];
        // [5] cts allow; flow gating only when cts is used
        pins_next[5] = (port_on && usage == UMC_USE_FLOW) ?
                       !i_clear_to_send_pin_n : 1'b1;
        // infrared encoder: zero bit sent as a short high pulse
        pins_next[6] = mode_reg[UMC_B_IR_ON] ?
                       (!i_tx_bit && i_ir_pulse) : i_tx_bit;
        pins_next[7] = port_on;
        // simplex or flow control on the request pin
        pins_next[8] = mode_reg[UMC_B_RTS_MODE] ? !i_tx_busy : !i_rx_ready;
        case (usage)
            UMC_USE_TXRX: pins_next[9] = 1'b0;
            UMC_USE_RTS:  pins_next[9] = port_on;
            UMC_USE_FLOW: pins_next[9] = port_on;
            UMC_USE_BCLK: begin
                pins_next[9] = port_on;
                pins_next[8] = i_baud_clk;
            end
            default:      pins_next[9] = 1'b0;
        endcase
        // [10..13] ownership: txrx, rts, cts, bclk
        // every pin released when off
        pins_next[10] = port_on;
        pins_next[11] = port_on &&
                        (usage == UMC_USE_RTS || usage == UMC_USE_FLOW);
        pins_next[12] = port_on && (usage == UMC_USE_FLOW);
        pins_next[13] = port_on && (usage == UMC_USE_BCLK);
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pins_reg <= 14'h0006;
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign o_rdata          = rdata_reg;
    assign o_irq            = irq_reg;
    assign o_mode           = mode_reg;
    assign o_run            = pins_reg[0];
    assign o_low_power      = pins_reg[1];
    assign o_rx_bit         = pins_reg[2];
    assign o_rx_accept      = pins_reg[3];
    assign o_measure_active = pins_reg[4];
    assign o_cts_allow      = pins_reg[5];
    assign o_serial_tx_pin  = pins_reg[6];
    assign o_serial_tx_oe   = pins_reg[7];
    assign o_rts_bclk_pin   = pins_reg[8];
    assign o_rts_bclk_oe    = pins_reg[9];
    assign o_own_txrx       = pins_reg[10];
    assign o_own_rts        = pins_reg[11];
    assign o_own_cts        = pins_reg[12];
    assign o_own_bclk       = pins_reg[13];
endmodule : umc_mode_ctrl

/* tb/umc_assertions.sv */
// umc_assertions: port-level checks of the serial mode control block.
// assumes one clock domain and the one-clock lag of every pin output.
`timescale 1ns/1ps
module umc_assertions (
    // clock, reset and register port
    input wire logic        i_mclk, i_reset_n, i_wr, i_rd,
    input wire logic [1:0]  i_addr,
    input wire logic [15:0] o_rdata, o_mode,
    // power state and datapath
    input wire logic        i_cpu_idle, i_cpu_sleep, i_tx_bit, i_ir_pulse,
    input wire logic        i_rx_ready, i_tx_busy, i_baud_clk,
    input wire logic        i_measure_done, o_run, o_low_power,
    input wire logic        o_rx_bit, o_rx_accept, i_serial_rx_pin,
    // pins and ownership
    input wire logic        o_serial_tx_pin, o_serial_tx_oe, o_rts_bclk_pin,
    input wire logic        o_own_txrx, o_own_rts, o_own_cts, o_own_bclk
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    logic       on;
    logic [1:0] use_sel;
    assign on = o_mode[15];
    assign use_sel = o_mode[9:8];
    a_port_owns: assert property (
        o_own_txrx == $past(on) && o_serial_tx_oe == $past(on))
        else $error("tx/rx ownership does not follow port_on");
    a_off_low_power: assert property (
        o_low_power == !$past(on)) else $error("low power not tied to off");
    a_usage_pins: assert property (
        {o_own_rts, o_own_cts, o_own_bclk} == $past({on && (use_sel == 2'h1
        || use_sel == 2'h2), on && use_sel == 2'h2, on && use_sel == 2'h3}))
        else $error("handshake pin ownership wrong for usage");
    a_unimpl_zero: assert property (
        o_mode[14] == 1'b0 && o_mode[10] == 1'b0)
        else $error("unimplemented mode bit set");
    a_read_mode: assert property (
        $past(i_rd && i_addr == 2'h0) |-> o_rdata == $past(o_mode))
        else $error("mode read data wrong");
    a_idle_halt: assert property (
        $past(i_reset_n) |-> o_run == $past(on && !i_cpu_sleep
        && !(i_cpu_idle && o_mode[13]))) else $error("run state wrong");
    a_ir_encode: assert property (
        $past(i_reset_n) |-> o_serial_tx_pin == $past(o_mode[12] ?
        (!i_tx_bit && i_ir_pulse) : i_tx_bit)) else $error("tx pin wrong");
    a_rts_mode: assert property (
        $past(i_reset_n) |-> o_rts_bclk_pin == $past(use_sel == 2'h3 ?
        i_baud_clk : (o_mode[11] ? !i_tx_busy : !i_rx_ready)))
        else $error("rts pin wrong for its mode");
    a_auto_rate_clear: assert property (
        o_mode[5] && i_measure_done && !(i_wr && i_addr == 2'h0)
        |=> !o_mode[5]) else $error("auto_rate_measure not cleared");
    a_wake_hold: assert property (
        o_mode[7] && !(i_wr && i_addr == 2'h0) &&
        !(i_serial_rx_pin && !$past(i_serial_rx_pin)) |=> o_mode[7])
        else $error("wake bit cleared without a receive rise");
    a_loop_rx: assert property (
        o_run && $past(o_mode[6]) |-> o_rx_bit == $past(i_tx_bit))
        else $error("loopback does not feed the transmit bit back");
    a_measure_gate: assert property (
        $past(i_reset_n) |-> o_rx_accept == (o_run && !$past(o_mode[5])))
        else $error("data accepted while rate measurement pending");
endmodule : umc_assertions
bind umc_mode_ctrl umc_assertions i_umc_assertions (.*);

/* tb/umc_far_end.sv */
// umc_far_end: remote transceiver driving the receive and cts lines.
// assumes the bench commands line level and cts hold per test.
`timescale 1ns/1ps
module umc_far_end (
    // clock and commands
    input  wire logic i_mclk,
    input  wire logic i_send_level,
    input  wire logic i_hold_off,
    // lines toward the port
    output logic      o_serial_rx_pin,
    output logic      o_clear_to_send_n
);
    // lines move only on an edge, like a real remote clocked driver
    always_ff @(posedge i_mclk) begin
        o_serial_rx_pin   <= i_send_level;
        o_clear_to_send_n <= i_hold_off;
    end
endmodule : umc_far_end

/* tb/testbench.sv */
// testbench: register-driven tests of the serial mode control block.
// assumes the checker is bound in and the far end model drives rx/cts.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    bad_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
    logic i_mclk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_cpu_idle = 0;
    logic i_cpu_sleep = 0, i_tx_bit = 0, i_ir_pulse = 0, i_rx_ready = 0;
    logic i_tx_busy = 0, i_baud_clk = 0, i_measure_done = 0;
    logic send_level = 1, hold_off = 1;
    logic [1:0] i_addr = 2'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata, o_mode;
    logic o_irq, o_run, o_low_power, o_rx_bit, o_rx_accept, o_cts_allow;
    logic o_measure_active, o_serial_tx_pin, o_serial_tx_oe, o_rts_bclk_pin;
    logic o_rts_bclk_oe, o_own_txrx, o_own_rts, o_own_cts, o_own_bclk;
    logic i_serial_rx_pin, i_clear_to_send_pin_n;
    logic [3:0] want;
    int bad_count = 0, samples_checked = 0;
    umc_mode_ctrl i_umc_mode_ctrl (.*);
    umc_far_end i_umc_far_end (.i_mclk(i_mclk), .i_send_level(send_level),
        .i_hold_off(hold_off), .o_serial_rx_pin(i_serial_rx_pin),
        .o_clear_to_send_n(i_clear_to_send_pin_n));
    always #50 i_mclk = ~i_mclk;
    always @(posedge i_mclk) i_baud_clk <= ~i_baud_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        tick(2);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask : rd
    task automatic close_out;
        $display("checks %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    initial begin
        #200_000;
        bad_count++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        tick(1);
        `CHK(o_low_power, 1'b1)
        rd(2'h0, 16'h0000);
        wr(2'h0, 16'hffff);
        rd(2'h0, 16'hbbff);
        wr(2'h3, 16'hffff);
        rd(2'h3, 16'h0000);
        $display("test registers done");
        for (logic [2:0] u = 0; u < 4; u++) begin
            wr(2'h0, {6'h20, u[1:0], 8'h00});
            want = {1'b1, u == 1 || u == 2, u == 2, u == 3};
            `CHK({o_own_txrx, o_own_rts, o_own_cts, o_own_bclk}, want)
            `CHK(o_cts_allow, u != 2)
            `CHK(o_rts_bclk_oe, u != 0)
        end
        wr(2'h0, 16'h0000);
        `CHK({o_own_txrx, o_own_rts, o_own_cts, o_low_power}, 4'h1)
        $display("test pin usage done");
        wr(2'h0, 16'ha000);
        @(posedge i_mclk) i_cpu_idle <= 1'b1;
        tick(2);
        `CHK(o_run, 1'b0)
        wr(2'h0, 16'h9000);
        `CHK(o_run, 1'b1)
        `CHK(o_rx_bit, 1'b0)
        @(posedge i_mclk) {i_tx_bit, i_ir_pulse} <= 2'b11;
        tick(2);
        `CHK(o_serial_tx_pin, 1'b0)
        @(posedge i_mclk) i_tx_bit <= 1'b0;
        tick(2);
        `CHK(o_serial_tx_pin, 1'b1)
        wr(2'h0, 16'h8100);
        `CHK({o_serial_tx_pin, o_rts_bclk_pin}, 2'b01)
        @(posedge i_mclk) i_tx_busy <= 1'b1;
        wr(2'h0, 16'h8900);
        `CHK(o_rts_bclk_pin, 1'b0)
        wr(2'h0, 16'h8040);
        `CHK(o_rx_bit, 1'b0)
        wr(2'h0, 16'h8010);
        `CHK(o_rx_bit, 1'b0)
        $display("test modes done");
        wr(2'h2, 16'h0003);
        wr(2'h0, 16'h8080);
        @(posedge i_mclk) i_cpu_sleep <= 1'b1;
        @(posedge i_mclk) send_level <= 1'b0;
        tick(3);
        `CHK(o_irq, 1'b1)
        @(posedge i_mclk) send_level <= 1'b1;
        tick(3);
        rd(2'h0, 16'h8000);
        wr(2'h2, 16'h0000);
        `CHK(o_irq, 1'b0)
        wr(2'h2, 16'h0003);
        wr(2'h1, 16'h0001);
        `CHK(o_irq, 1'b0)
        @(posedge i_mclk) i_cpu_sleep <= 1'b0;
        wr(2'h0, 16'h8020);
        `CHK({o_measure_active, o_rx_accept}, 2'b10)
        @(posedge i_mclk) i_measure_done <= 1'b1;
        @(posedge i_mclk) i_measure_done <= 1'b0;
        tick(2);
        rd(2'h0, 16'h8000);
        `CHK(o_irq, 1'b1)
        wr(2'h1, 16'h0002);
        `CHK(o_irq, 1'b0)
        $display("test events done");
        close_out;
    end
endmodule : testbench
